/* File: hdl/dsli_top.sv */
module dsli_top
   import dsli_pkg::*;
#(
   parameter int DAC_BITS = DSLI_BITS_12
)
(
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial link from the host
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic load_strobe_n,
   input wire logic clear_to_zero_n,
   // Converter code and status
   output logic [DSLI_MAX_BITS-1:0] dac_code_ff,
   output logic dac_zero_scale_ff,
   output logic dac_upper_half_ff,
   output logic dac_load_done_ff
);
   timeunit 1ns;
   timeprecision 1ns;

   // Midscale code of the selected variant
   localparam logic [DSLI_MAX_BITS-1:0] MID_CODE =
      (DAC_BITS == DSLI_BITS_10) ? DSLI_MID_10 : DSLI_MID_12;

   // ------------------------------------------------------------------
   // System clock reset: asserted at once, released through two flops
   // ------------------------------------------------------------------

   // Reset release chain in the system domain
   logic [1:0] rst_sync_ff;
   // Internal active-low reset for the system domain
   logic sys_rst_n;

   // Shift a one in after release; clear at once on assertion
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync_ff <= DSLI_RST_SYNC_INIT;
      end
      else
      begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign sys_rst_n = rst_sync_ff[1];

   // ------------------------------------------------------------------
   // Link clock reset: same scheme on the serial clock
   // ------------------------------------------------------------------

   // Reset release chain in the link domain
   logic [1:0] link_rst_sync_ff;
   // Internal active-low reset for the link domain
   logic link_rst_n;

   // The serial clock may stand still, so release waits for its edges
   always_ff @(posedge serial_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_rst_sync_ff <= DSLI_RST_SYNC_INIT;
      end
      else
      begin
         link_rst_sync_ff <= {link_rst_sync_ff[0], 1'b1};
      end
   end

   assign link_rst_n = link_rst_sync_ff[1];

   // ------------------------------------------------------------------
   // Link domain: input shift register
   // ------------------------------------------------------------------

   // Serial input word, newest bit in bit zero
   logic [DAC_BITS-1:0] shift_ff;
   // Next value of the serial input word
   logic [DAC_BITS-1:0] nxt_shift;

   // Load strobe and data come from the host in step with its own clock,
   // so they are sampled directly on the serial clock
   always_comb
   begin
      nxt_shift = shift_ff;
      // Shifting is only enabled while the load strobe is high
      if (load_strobe_n)
      begin
         // Older bits move up, the earliest excess bits fall off the top
         nxt_shift = {shift_ff[DAC_BITS-2:0], serial_data_in};
      end
   end

   // Register the word on each rising serial clock edge
   always_ff @(posedge serial_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         shift_ff <= '0;
      end
      else
      begin
         shift_ff <= nxt_shift;
      end
   end

   // ------------------------------------------------------------------
   // Control pins into the system domain
   // ------------------------------------------------------------------

   // First synchroniser stage, read only by the second stage
   dsli_ctrl_type ctrl_meta_ff;
   // Second synchroniser stage
   dsli_ctrl_type ctrl_sync_ff;
   // Previous synchronised value, for edge detection
   dsli_ctrl_type ctrl_prev_ff;

   // Two flops per pin, then one more for the edge detectors
   always_ff @(posedge clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         ctrl_meta_ff <= DSLI_CTRL_IDLE;
         ctrl_sync_ff <= DSLI_CTRL_IDLE;
         ctrl_prev_ff <= DSLI_CTRL_IDLE;
      end
      else
      begin
         ctrl_meta_ff <= '{load_n: load_strobe_n, clear_n: clear_to_zero_n};
         ctrl_sync_ff <= ctrl_meta_ff;
         ctrl_prev_ff <= ctrl_sync_ff;
      end
   end

   // Falling edge of the synchronised load strobe
   logic load_fall;
   // Rising edge of the synchronised clear input
   logic clear_rise;

   assign load_fall = ctrl_prev_ff.load_n & ~ctrl_sync_ff.load_n;
   assign clear_rise = ~ctrl_prev_ff.clear_n & ctrl_sync_ff.clear_n;

   // ------------------------------------------------------------------
   // Word crossing: the shift word is frozen while the strobe is low
   // ------------------------------------------------------------------

   // The strobe going low stops shifting before it is seen here through
   // two flops, so the word is stable when captured; a single capture
   // register keeps the decision logic away from a moving bus
   logic [DAC_BITS-1:0] word_hold_ff;
   // Next value of the held word
   logic [DAC_BITS-1:0] nxt_word_hold;

   // Track the shift word only while the synchronised strobe is low
   always_comb
   begin
      nxt_word_hold = word_hold_ff;
      if (!ctrl_sync_ff.load_n)
      begin
         nxt_word_hold = shift_ff;
      end
   end

   // Register the held word
   always_ff @(posedge clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         word_hold_ff <= '0;
      end
      else
      begin
         word_hold_ff <= nxt_word_hold;
      end
   end

   // Delayed edges so the transfer uses the already held word
   logic load_fall_ff;
   // Delayed clear release
   logic clear_rise_ff;

   // One-cycle delay of the edge pulses
   always_ff @(posedge clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         load_fall_ff <= 1'b0;
         clear_rise_ff <= 1'b0;
      end
      else
      begin
         load_fall_ff <= load_fall;
         clear_rise_ff <= clear_rise;
      end
   end

   // ------------------------------------------------------------------
   // DAC register and load control
   // ------------------------------------------------------------------

   // Load control state
   dsli_state_type state_ff;
   // Next load control state
   dsli_state_type nxt_state;
   // Next DAC code
   logic [DSLI_MAX_BITS-1:0] nxt_dac_code;
   // Next load completion pulse
   logic nxt_load_done;

   // Decide when the DAC register changes
   always_comb
   begin
      nxt_state = state_ff;
      nxt_dac_code = dac_code_ff;
      nxt_load_done = 1'b0;
      unique case (state_ff)
         // Normal operation: wait for a strobe or a clear
         DSLI_ST_RUN:
         begin
            if (!ctrl_sync_ff.clear_n)
            begin
               // Clear wins over any strobe edge in the same cycle
               nxt_state = DSLI_ST_CLEAR;
               nxt_dac_code = DSLI_ZERO_CODE;
            end
            else if (load_fall_ff)
            begin
               // Copy the captured word; besides clear, the register is also loaded in DSLI_ST_HELD
               nxt_dac_code = DSLI_MAX_BITS'(word_hold_ff);
               nxt_load_done = 1'b1;
            end
         end
         // Clear held low: keep the register at zero
         DSLI_ST_CLEAR:
         begin
            nxt_dac_code = DSLI_ZERO_CODE;
            if (ctrl_sync_ff.clear_n)
            begin
               // Wait one cycle so the held word is current
               nxt_state = DSLI_ST_HELD;
            end
         end
         // Clear just released: load at once if the strobe is still low
         DSLI_ST_HELD:
         begin
            nxt_state = DSLI_ST_RUN;
            if (!ctrl_sync_ff.clear_n)
            begin
               nxt_state = DSLI_ST_CLEAR;
               nxt_dac_code = DSLI_ZERO_CODE;
            end
            else if (!ctrl_sync_ff.load_n || clear_rise_ff)
            begin
               if (!ctrl_sync_ff.load_n)
               begin
                  // Host left the strobe low across the release
                  nxt_dac_code = DSLI_MAX_BITS'(word_hold_ff);
                  nxt_load_done = 1'b1;
               end
            end
         end
         // Unused code: return to zero scale
         default:
         begin
            nxt_state = DSLI_ST_CLEAR;
            nxt_dac_code = DSLI_ZERO_CODE;
         end
      endcase
   end

   // Register load control and the DAC code
   always_ff @(posedge clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         state_ff <= DSLI_ST_RUN;
         dac_code_ff <= DSLI_ZERO_CODE;
         dac_load_done_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         dac_code_ff <= nxt_dac_code;
         dac_load_done_ff <= nxt_load_done;
      end
   end

   // ------------------------------------------------------------------
   // Code status flags
   // ------------------------------------------------------------------

   // Next zero-scale flag
   logic nxt_zero_scale;
   // Next upper-half flag (non-negative in offset binary)
   logic nxt_upper_half;

   // Flags follow the next code so they line up with dac_code_ff
   always_comb
   begin
      nxt_zero_scale = (nxt_dac_code == DSLI_ZERO_CODE);
      nxt_upper_half = (nxt_dac_code >= MID_CODE);
   end

   // Register the status flags
   always_ff @(posedge clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         dac_zero_scale_ff <= 1'b1;
         dac_upper_half_ff <= 1'b0;
      end
      else
      begin
         dac_zero_scale_ff <= nxt_zero_scale;
         dac_upper_half_ff <= nxt_upper_half;
      end
   end

endmodule : dsli_top

/* File: shared/dsli_pkg.sv */
// Shared constants and types for the serial-load DAC front end
package dsli_pkg;

   // Converter widths of the two variants
   localparam int DSLI_BITS_12 = 12;
   localparam int DSLI_BITS_10 = 10;

   // Width of the widest variant, used for the ports
   localparam int DSLI_MAX_BITS = 12;

   // Zero-scale code forced by clear
   localparam logic [11:0] DSLI_ZERO_CODE = 12'h000;

   // Midscale code of the 12-bit variant (zero in offset binary)
   localparam logic [11:0] DSLI_MID_12 = 12'h800;

   // Midscale code of the 10-bit variant (zero in offset binary)
   localparam logic [11:0] DSLI_MID_10 = 12'h200;

   // Reset values of the synchronised control pins (inactive, high)
   localparam logic DSLI_PIN_IDLE = 1'b1;

   // Two-flop synchroniser reset value for the internal reset
   localparam logic [1:0] DSLI_RST_SYNC_INIT = 2'h0;

   // Load control states
   typedef enum logic [1:0] {
      DSLI_ST_RUN = 2'b00,
      DSLI_ST_CLEAR = 2'b01,
      DSLI_ST_HELD = 2'b10
   } dsli_state_type;

   // Control pins as seen in the system clock domain after synchronising
   typedef struct packed {
      logic load_n;
      logic clear_n;
   } dsli_ctrl_type;

   // Reset value of the synchronised control bundle
   localparam dsli_ctrl_type DSLI_CTRL_IDLE = '{load_n: 1'b1, clear_n: 1'b1};

endpackage : dsli_pkg

/* File: testbench/dsli_properties.sv */
module dsli_properties
   import dsli_pkg::*;
#(parameter int DAC_BITS = DSLI_BITS_12)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control pins
   input wire logic load_strobe_n,
   input wire logic clear_to_zero_n,
   // Converter outputs
   input wire logic [DSLI_MAX_BITS-1:0] dac_code_ff,
   input wire logic dac_zero_scale_ff,
   input wire logic dac_upper_half_ff,
   input wire logic dac_load_done_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // Midscale of this variant
   localparam logic [11:0] MID = (DAC_BITS == 10) ? DSLI_MID_10 : DSLI_MID_12;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Strobe falls while clear is off
   sequence s_fall;
      $fell(load_strobe_n) && clear_to_zero_n;
   endsequence
   // Clear lets go with the strobe still low
   sequence s_rel;
      $rose(clear_to_zero_n) && !load_strobe_n;
   endsequence
   property p_load;
      s_fall |-> ##[2:5] dac_load_done_ff;
   endproperty
   a_load: assert property (p_load) else $error("no load after strobe fall");
   property p_rel;
      s_rel |-> ##[2:6] dac_load_done_ff;
   endproperty
   a_rel: assert property (p_rel) else $error("no load at clear release");
   property p_clr;
      !clear_to_zero_n [*5] |-> dac_code_ff == DSLI_ZERO_CODE && !dac_load_done_ff;
   endproperty
   a_clr: assert property (p_clr) else $error("code not zero in clear");
   property p_hold;
      $changed(dac_code_ff) |-> dac_load_done_ff || dac_code_ff == DSLI_ZERO_CODE;
   endproperty
   a_hold: assert property (p_hold) else $error("code moved without load");
   property p_cause;
      dac_load_done_ff |-> !$past(load_strobe_n, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("load without strobe low");
   property p_pulse;
      dac_load_done_ff |=> !dac_load_done_ff;
   endproperty
   a_pulse: assert property (p_pulse) else $error("load pulse too long");
   property p_zero;
      dac_zero_scale_ff == (dac_code_ff == DSLI_ZERO_CODE);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_upper;
      dac_upper_half_ff == (dac_code_ff >= MID);
   endproperty
   a_upper: assert property (p_upper) else $error("upper flag wrong");
endmodule : dsli_properties

bind dsli_top dsli_properties #(.DAC_BITS(DAC_BITS)) u_chk (.*);

/* File: testbench/dsli_host.sv */
module dsli_host
   import dsli_pkg::*;
(
   // System clock
   input wire logic clk,
   // Pins toward the converter
   output logic serial_clk,
   output logic serial_data_in,
   output logic load_strobe_n,
   output logic clear_to_zero_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle pins
   initial
   begin
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
      load_strobe_n = 1'b1;
      clear_to_zero_n = 1'b1;
   end
   // Sixteen clocks, top bit first; clock still outside the frame
   task send(input logic [15:0] w);
      for (int i = 15; i >= 0; i--)
      begin
         #5 serial_data_in = w[i];
         #11 serial_clk = 1'b1;
         #16 serial_clk = 1'b0;
      end
      serial_data_in = ~w[0];
      #40;
   endtask : send
   // Set strobe and clear at a clock edge, then hold them
   task pins(input logic ld, input logic cl);
      @(posedge clk);
      load_strobe_n <= ld;
      clear_to_zero_n <= cl;
      repeat (7) @(posedge clk);
   endtask : pins
endmodule : dsli_host

/* File: testbench/dsli_top_tb.sv */
module dsli_top_tb;
   import dsli_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // Pins and outputs
   logic clk, rst_n, serial_clk, serial_data_in, load_strobe_n, clear_to_zero_n;
   logic [11:0] dac_code_ff;
   logic dac_zero_scale_ff, dac_upper_half_ff, dac_load_done_ff;
   // Outputs of the ten-bit variant
   logic [11:0] code_10;
   logic zero_10;
   logic upper_10;
   // Counters
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int dones = 0;
   dsli_host host (.*);
   dsli_top #(.DAC_BITS(DSLI_BITS_12)) dut (.*);
   // Ten-bit variant on the same pins
   dsli_top #(.DAC_BITS(DSLI_BITS_10)) dut_10 (
      .clk(clk),
      .rst_n(rst_n),
      .serial_clk(serial_clk),
      .serial_data_in(serial_data_in),
      .load_strobe_n(load_strobe_n),
      .clear_to_zero_n(clear_to_zero_n),
      .dac_code_ff(code_10),
      .dac_zero_scale_ff(zero_10),
      .dac_upper_half_ff(upper_10),
      .dac_load_done_ff()
   );
   // System clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Count load pulses and cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (dac_load_done_ff === 1'b1)
         dones <= dones + 1;
      if (cycles == 3000)
      begin
         bad_count++;
         results();
      end
   end
   task check(input logic [11:0] seen, input logic [11:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask : check
   // Two-byte frames loaded in turn
   task t_frames();
      logic [15:0] w [5];
      logic [11:0] prev;
      int n;
      w = '{16'hf123, 16'h0800, 16'h07ff, 16'h5fff, 16'ha000};
      prev = 12'h000;
      foreach (w[i])
      begin
         n = dones;
         host.send(w[i]);
         check(dac_code_ff, prev, "held");
         host.pins(1'b0, 1'b1);
         check(dac_code_ff, w[i][11:0], "code");
         check(12'(dones - n), 12'h001, "pulse");
         check(12'(dac_zero_scale_ff), 12'(w[i][11:0] == 0), "zero");
         check(12'(dac_upper_half_ff), 12'(w[i][11]), "upper");
         check(code_10, {2'h0, w[i][9:0]}, "code 10");
         check(12'(zero_10), 12'(w[i][9:0] == 0), "zero 10");
         check(12'(upper_10), 12'(w[i][9]), "upper 10");
         host.pins(1'b1, 1'b1);
         prev = w[i][11:0];
      end
      $display("frames test done");
   endtask : t_frames
   // Clocks with the strobe low are ignored
   task t_ignore();
      host.send(16'h0abc);
      host.pins(1'b0, 1'b1);
      host.send(16'h0123);
      host.pins(1'b1, 1'b1);
      host.pins(1'b0, 1'b1);
      check(dac_code_ff, 12'habc, "ignored");
      check(code_10, 12'h2bc, "ignored 10");
      host.pins(1'b1, 1'b1);
      $display("ignore test done");
   endtask : t_ignore
   // Clear forces zero, beats the strobe, loads on release if strobe low
   task t_clear();
      host.send(16'h0456);
      host.pins(1'b1, 1'b0);
      check(dac_code_ff, 12'h000, "clear");
      host.pins(1'b0, 1'b0);
      check(dac_code_ff, 12'h000, "override");
      host.pins(1'b1, 1'b0);
      host.pins(1'b1, 1'b1);
      check(dac_code_ff, 12'h000, "release");
      host.pins(1'b1, 1'b0);
      host.pins(1'b0, 1'b0);
      host.pins(1'b0, 1'b1);
      check(dac_code_ff, 12'h456, "late load");
      check(code_10, 12'h056, "late load 10");
      host.pins(1'b1, 1'b1);
      $display("clear test done");
   endtask : t_clear
   task results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   // Reset, then the scenarios
   initial
   begin
      rst_n = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_frames();
      t_ignore();
      t_clear();
      results();
   end
endmodule : dsli_top_tb
